// [common/ddri_pkg.sv]
// Constants, field positions and carriers for the DDR command, mode and read path.
// Assumes a 200 MHz core clock that oversamples the controller's much slower clock.
// Summary of operation
// - Extended write: all strobes low, bank bit 0 high; stores address and bank bit 1.
// - Extended bit 0 selects loop enable; bit 1 selects full or half drive.
// - Mode write: all strobes and bank bit 0 low; stores address 0 to 11.
// - Mode fields: length 2..0, type 3, latency 6..4, test 7, loop reset 8.
// - Burst lengths of 2, 4 and 8 words are supported.
// - Sequential order increments from the start, wrapping within the aligned block.
// - Interleave order is start offset XOR a beat counter.
// - Activation: select and row strobe low, column strobe and write high; bank chosen.
// - Read strobe and data are launched together from the same phase.
// - First read burst: strobe leaves high impedance low about one clock before data.
// - After the last burst: strobe held low, released half a clock after data.
// - Back-to-back read bursts stream with no preamble or postamble between them.
// - Address bit 10 with a read selects auto-precharge; low keeps the bank open.
// - Auto-precharge starts read latency after last data, not before minimum active time.
// - Chip select high ignores new commands; running operations complete.
package ddri_pkg;
   localparam int CLK_PS = 5000;
   localparam int ACT_MIN_NS = 40;
   localparam logic [3:0] ACT_MIN_CYC = 4'((ACT_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS);
   localparam logic [7:0] DLL_LOCK_CK = 8'hC8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int MEM_AW = 7;
   localparam int PIPE_N = 6;
   localparam int PRE_IDX = 2;
   localparam int MR_BL_LO = 0;
   localparam int MR_BL_HI = 2;
   localparam int MR_BT = 3;
   localparam int MR_CL_LO = 4;
   localparam int MR_CL_HI = 6;
   localparam int MR_DLLRST = 8;
   localparam int ER_DLL = 0;
   localparam int ER_HALF = 1;
   localparam int AP_BIT = 10;
   localparam logic [2:0] BL2 = 3'h1;
   localparam logic [2:0] BL4 = 3'h2;
   localparam logic [2:0] BL8 = 3'h3;
   localparam logic [2:0] CL2 = 3'h2;
   localparam logic [2:0] CL3 = 3'h3;
   localparam logic [2:0] CL25 = 3'h6;
   localparam logic [2:0] H_CL2 = 3'h4;
   localparam logic [2:0] H_CL25 = 3'h5;
   localparam logic [2:0] H_CL3 = 3'h6;
   localparam logic [3:0] BEATS2 = 4'h2;
   localparam logic [3:0] BEATS4 = 4'h4;
   localparam logic [3:0] BEATS8 = 4'h8;
   localparam logic [11:0] MODE_RST = 12'h032;
   localparam logic [12:0] EXT_RST = 13'h0000;
   localparam logic [3:0] ALL_BANKS = 4'hF;
   localparam logic [3:0] CMD_MODE = 4'h0;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
   } ddri_cmd_s;

   typedef struct packed {
      logic ck;
      logic cke;
      ddri_cmd_s cmd;
      logic [1:0] ba;
      logic [ADDR_W-1:0] addr;
   } ddri_pins_s;

   typedef struct packed {
      logic valid;
      logic ap;
      logic [1:0] ba;
      logic [4:0] col;
   } ddri_job_s;
endpackage

// [logic/ddri_core.sv]
// DDR device command decode, mode registers, bank state and read strobe/data path.
// Assumes controller pins are asynchronous to clk and its clock is far slower.
`timescale 1ns/1ps
`default_nettype none
module ddri_core
   import ddri_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ck,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dqIn,
   output logic [DATA_W-1:0] dqOut,
   output logic dqOe,
   input wire logic dqsIn,
   output logic dqsOut,
   output logic dqsOe,
   input wire logic preloadEn,
   input wire logic [MEM_AW-1:0] preloadAddr,
   input wire logic [DATA_W-1:0] preloadData,
   output logic [3:0] bankOpen,
   output logic [11:0] modeReg,
   output logic [12:0] extReg,
   output logic dllOn,
   output logic halfDrive,
   output logic dllLocking
);
   function automatic logic [3:0] burstBeats(input logic [2:0] code);
      case (code)
         BL2: burstBeats = BEATS2;
         BL4: burstBeats = BEATS4;
         BL8: burstBeats = BEATS8;
         default: burstBeats = BEATS2;
      endcase
   endfunction

   function automatic logic [2:0] latHalves(input logic [2:0] code);
      case (code)
         CL2: latHalves = H_CL2;
         CL25: latHalves = H_CL25;
         CL3: latHalves = H_CL3;
         default: latHalves = H_CL3;
      endcase
   endfunction

   function automatic logic [2:0] burstCol(input logic [2:0] start, input logic [2:0] beat,
                                           input logic [3:0] beats, input logic inter);
      logic [2:0] mask;
      mask = 3'(beats - 4'h1);
      burstCol = (start & ~mask) | ((inter ? (start ^ beat) : 3'(start + beat)) & mask);
   endfunction

   // Pin sampling; the third stage serves edge finding and supplies the command fields
   ddri_pins_s pinsIn, sync1_q, sync2_q, prev_q;
   assign pinsIn = {ck, cke, csN, rasN, casN, weN, ba, addr};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= pinsIn;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Command fields come from the sample just before the rising edge
   wire ckRise = sync2_q.ck & ~prev_q.ck;
   wire ckFall = ~sync2_q.ck & prev_q.ck;
   wire halfEdge = ckRise | ckFall;
   wire cmdTaken = ckRise & prev_q.cke & ~prev_q.cmd.csN;
   wire [3:0] baHot = 4'(4'h1 << prev_q.ba);
   wire isAct = cmdTaken & (prev_q.cmd == CMD_ACT);
   wire isRead = cmdTaken & (prev_q.cmd == CMD_READ);
   wire isPre = cmdTaken & (prev_q.cmd == CMD_PRE);
   wire isMode = cmdTaken & (prev_q.cmd == CMD_MODE) & ~prev_q.ba[0];
   wire isExt = cmdTaken & (prev_q.cmd == CMD_MODE) & prev_q.ba[0];

   logic [11:0] modeReg_q;
   logic [12:0] extReg_q;
   logic dllOn_q, halfDrive_q, dllLocking_q;
   logic [7:0] lockCnt_q, lockCnt_d;
   wire [3:0] blBeats = burstBeats(modeReg_q[MR_BL_HI:MR_BL_LO]);
   wire interleave = modeReg_q[MR_BT];
   wire [2:0] latH = latHalves(modeReg_q[MR_CL_HI:MR_CL_LO]);
   wire dllReset = isMode & prev_q.addr[MR_DLLRST];
   assign lockCnt_d = dllReset ? DLL_LOCK_CK :
                      (ckRise && lockCnt_q != 8'h00) ? 8'(lockCnt_q - 8'h01) : lockCnt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         modeReg_q <= MODE_RST;
         extReg_q <= EXT_RST;
         dllOn_q <= 1'b0;
         halfDrive_q <= 1'b0;
         lockCnt_q <= 8'h00;
         dllLocking_q <= 1'b0;
      end else begin
         if (isMode) begin
            modeReg_q <= prev_q.addr;
         end
         if (isExt) begin
            extReg_q <= {prev_q.ba[1], prev_q.addr};
            dllOn_q <= ~prev_q.addr[ER_DLL];
            halfDrive_q <= prev_q.addr[ER_HALF];
         end
         lockCnt_q <= lockCnt_d;
         dllLocking_q <= lockCnt_d != 8'h00;
      end
   end

   // Bank state and auto-precharge
   logic [3:0] bankOpen_q, apClose;
   logic [3:0] age_q [4];
   logic apArm_q, curAp_q;
   logic [1:0] apBank_q, curBank_q;
   logic [2:0] apCnt_q;
   logic [3:0] beats_q;
   ddri_job_s pipe_q [PIPE_N];
   wire startNow = pipe_q[0].valid;
   wire lastBeat = halfEdge & ~startNow & (beats_q == 4'h1);
   // Precharge after latency and minimum active time
   wire apFire = apArm_q & (apCnt_q == 3'h0) & (age_q[apBank_q] >= ACT_MIN_CYC);
   assign apClose = apFire ? 4'(4'h1 << apBank_q) : 4'h0;
   wire [3:0] preMask = isPre ? (prev_q.addr[AP_BIT] ? ALL_BANKS : baHot) : 4'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bankOpen_q <= 4'h0;
         apArm_q <= 1'b0;
         apBank_q <= 2'h0;
         apCnt_q <= 3'h0;
         for (int i = 0; i < 4; i++) begin
            age_q[i] <= 4'h0;
         end
      end else begin
         bankOpen_q <= (bankOpen_q | (isAct ? baHot : 4'h0)) & ~preMask & ~apClose;
         for (int i = 0; i < 4; i++) begin
            age_q[i] <= (isAct && baHot[i]) ? 4'h0 :
                        (age_q[i] < ACT_MIN_CYC) ? 4'(age_q[i] + 4'h1) : age_q[i];
         end
         // Arm at last beat of an auto-precharge read
         if (lastBeat && curAp_q) begin
            apArm_q <= 1'b1;
            apBank_q <= curBank_q;
            apCnt_q <= latH;
         end else if (apFire) begin
            apArm_q <= 1'b0;
         end else if (halfEdge && apCnt_q != 3'h0) begin
            apCnt_q <= 3'(apCnt_q - 3'h1);
         end
      end
   end

   // Read latency line, one slot per half clock
   ddri_job_s newJob;
   assign newJob = '{valid: isRead & bankOpen_q[prev_q.ba], ap: prev_q.addr[AP_BIT],
                     ba: prev_q.ba, col: prev_q.addr[4:0]};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PIPE_N; i++) begin
            pipe_q[i] <= '0;
         end
      end else if (halfEdge) begin
         for (int i = 0; i < PIPE_N - 1; i++) begin
            pipe_q[i] <= pipe_q[i + 1];
         end
         pipe_q[PIPE_N - 1] <= '0;
         if (isRead) begin
            pipe_q[3'(latH - 3'h1)] <= newJob;
         end
      end
   end

   // Fetch side: runs ahead of the pins, stalled by the buffer
   ddri_job_s genJob_q, nextJob_q;
   logic genBusy_q, memRdValid_q, bufInReady, bufOutValid;
   logic [2:0] genBeat_q;
   logic [DATA_W-1:0] memRdData, bufData;
   wire grab = halfEdge & pipe_q[PRE_IDX].valid;
   wire issue = genBusy_q & bufInReady & ~memRdValid_q;
   wire genDone = issue & (genBeat_q == 3'(blBeats - 4'h1));
   wire genFree = ~genBusy_q | genDone;
   wire loadNext = genFree & nextJob_q.valid;
   wire loadGrab = genFree & ~nextJob_q.valid & grab;
   wire [MEM_AW-1:0] memAddr = {genJob_q.ba, genJob_q.col[4:3],
                                burstCol(genJob_q.col[2:0], genBeat_q, blBeats, interleave)};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         genJob_q <= '0;
         nextJob_q <= '0;
         genBusy_q <= 1'b0;
         genBeat_q <= 3'h0;
         memRdValid_q <= 1'b0;
      end else begin
         memRdValid_q <= issue;
         if (loadNext || loadGrab) begin
            genJob_q <= loadNext ? nextJob_q : pipe_q[PRE_IDX];
            genBusy_q <= 1'b1;
            genBeat_q <= 3'h0;
         end else begin
            genBusy_q <= genBusy_q & ~genDone;
            genBeat_q <= issue ? 3'(genBeat_q + 3'h1) : genBeat_q;
         end
         if (loadNext) begin
            nextJob_q <= grab ? pipe_q[PRE_IDX] : '0;
         end else if (grab && !loadGrab) begin
            nextJob_q <= pipe_q[PRE_IDX];
         end
      end
   end

   ddri_mem u_mem (
      .clk(clk),
      .wrEn(preloadEn),
      .wrAddr(preloadAddr),
      .wrData(preloadData),
      .rdEn(issue),
      .rdAddr(memAddr),
      .rdData(memRdData)
   );

   wire beatNow = halfEdge & (startNow | (beats_q != 4'h0));
   ddri_fifo2 #(.WIDTH(DATA_W), .DEPTH(2)) u_buf (
      .clk(clk),
      .rst(rst),
      .inValid(memRdValid_q),
      .inReady(bufInReady),
      .inData(memRdData),
      .outValid(bufOutValid),
      .outReady(beatNow),
      .outData(bufData)
   );

   // Pin stage: one word per controller clock edge
   logic [DATA_W-1:0] dq_q;
   logic dqOe_q, dqs_q, dqsOe_q, post_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_q <= '0;
         dqOe_q <= 1'b0;
         dqs_q <= 1'b0;
         dqsOe_q <= 1'b0;
         post_q <= 1'b0;
         beats_q <= 4'h0;
         curAp_q <= 1'b0;
         curBank_q <= 2'h0;
      end else if (halfEdge) begin
         // Strobe toggles with each word, no break between bursts
         if (beatNow) begin
            dq_q <= bufData;
            dqOe_q <= 1'b1;
            dqs_q <= ~dqs_q;
            dqsOe_q <= 1'b1;
            post_q <= 1'b0;
            beats_q <= startNow ? 4'(blBeats - 4'h1) : 4'(beats_q - 4'h1);
            if (startNow) begin
               curAp_q <= pipe_q[0].ap;
               curBank_q <= pipe_q[0].ba;
            end
         // Postamble low for half a clock
         end else if (dqOe_q) begin
            dqOe_q <= 1'b0;
            dqs_q <= 1'b0;
            post_q <= 1'b1;
         end else if (pipe_q[PRE_IDX].valid) begin
            dqsOe_q <= 1'b1;
            dqs_q <= 1'b0;
            post_q <= 1'b0;
         end else if (post_q) begin
            dqsOe_q <= 1'b0;
            post_q <= 1'b0;
         end
      end
   end

   assign dqOut = dq_q;
   assign dqOe = dqOe_q;
   assign dqsOut = dqs_q;
   assign dqsOe = dqsOe_q;
   assign bankOpen = bankOpen_q;
   assign modeReg = modeReg_q;
   assign extReg = extReg_q;
   assign dllOn = dllOn_q;
   assign halfDrive = halfDrive_q;
   assign dllLocking = dllLocking_q;

   // Helper: half edges spent in preamble before data
   logic [1:0] preCnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preCnt_q <= 2'h0;
      end else if (dqOe_q || !dqsOe_q) begin
         preCnt_q <= 2'h0;
      end else if (halfEdge && preCnt_q != 2'h3) begin
         preCnt_q <= 2'(preCnt_q + 2'h1);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_ext_write_store: assert property (isExt |=> extReg_q == {$past(prev_q.ba[1]), $past(prev_q.addr)})
      else $error("extended register not stored");
   a_drive_select: assert property (isExt |=> halfDrive_q == $past(prev_q.addr[1]) && dllOn_q == !$past(prev_q.addr[0]))
      else $error("drive strength or loop enable wrong");
   a_mode_write_store: assert property (isMode |=> modeReg_q == $past(prev_q.addr))
      else $error("mode register not stored");
   a_loop_reset_count: assert property (dllReset |=> dllLocking_q && lockCnt_q == DLL_LOCK_CK)
      else $error("loop reset did not start lock count");
   a_act_opens_bank: assert property (isAct && !apFire |=> bankOpen_q[$past(prev_q.ba)])
      else $error("activation did not open bank");
   a_deselect_ignored: assert property (ckRise && prev_q.cmd.csN |=> $stable(modeReg_q) && $stable(extReg_q))
      else $error("command taken while deselected");
   a_burst_length: assert property (halfEdge && startNow |=> dqOe_q && beats_q == $past(blBeats) - 4'h1)
      else $error("burst did not load its length");
   a_strobe_with_data: assert property (beatNow |=> dqOe_q && dqsOe_q && dqs_q != $past(dqs_q))
      else $error("strobe not launched with data");
   a_preamble_low: assert property ($rose(dqOe_q) && !$past(post_q) |-> preCnt_q >= 2'h2 && !$past(dqs_q))
      else $error("read preamble shorter than one clock");
   a_postamble_low: assert property ($fell(dqOe_q) |-> dqsOe_q && !dqs_q)
      else $error("postamble not held low");
   a_gapless_read: assert property (halfEdge && startNow && dqOe_q |=> dqOe_q && dqsOe_q && !post_q)
      else $error("gap inserted between bursts");
   a_ap_arm: assert property (lastBeat && curAp_q |=> apArm_q && apCnt_q == $past(latH))
      else $error("auto-precharge not armed at last beat");
   a_ap_active_min: assert property ($fell(bankOpen_q[apBank_q]) && $past(apFire) |-> $past(age_q[apBank_q]) >= ACT_MIN_CYC)
      else $error("auto-precharge before minimum active time");
   a_data_ready: assert property (beatNow |-> bufOutValid)
      else $error("read word not ready at its edge");

   c_read_burst: cover property ($rose(dqOe_q));
   c_gapless: cover property (halfEdge && startNow && dqOe_q);
   c_ap_close: cover property (apFire);
   c_ext_write: cover property (isExt);
endmodule
`default_nettype wire

// [logic/ddri_core_fix.sv]
// Intentionally empty.

// [logic/ddri_fifo2.sv]
// Two-entry valid/ready buffer between the data store and the pin stage.
// Assumes DEPTH is a power of two; both sides on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ddri_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
   logic [WIDTH-1:0] slot_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign inReady = cnt_q != FULL;
   assign outValid = cnt_q != '0;
   assign outData = slot_q[rp_q];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= push ? PW'(wp_q + 1'b1) : wp_q;
         rp_q <= pop ? PW'(rp_q + 1'b1) : rp_q;
         cnt_q <= (PW + 1)'(cnt_q + push - pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         slot_q[wp_q] <= inData;
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst) cnt_q <= FULL)
      else $error("buffer count above depth");
endmodule
`default_nettype wire

// [logic/ddri_mem.sv]
// Small read-data store for the read path, with a preload port.
// Assumes one clock; read data is registered, one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module ddri_mem
   import ddri_pkg::*;
(
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [MEM_AW-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic rdEn,
   input wire logic [MEM_AW-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);
   logic [DATA_W-1:0] store [2**MEM_AW];

   // No reset: contents are whatever was preloaded
   always_ff @(posedge clk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
      if (rdEn) begin
         rdData <= store[rdAddr];
      end
   end
endmodule
`default_nettype wire

// [tb/ddri_ctl_model.sv]
// Controller model: free running ck, command pins, read capture.
// Assumes the bench calls start, then issue; pins move at ck fall.
`timescale 1ns/1ps
`default_nettype none
module ddri_ctl_model
   import ddri_pkg::*;
(
   output logic ck,
   output logic cke,
   output ddri_cmd_s cmd,
   output logic [1:0] ba,
   output logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq,
   input wire logic dqOe,
   input wire logic dqsOe
);
   logic [DATA_W-1:0] q[$];
   int half = 0;
   int first = 0;
   int tick = 0;
   int ft = 0;
   int last = 0;
   initial begin
      ck = 1'b0;
      cke = 1'b0;
      cmd = 4'hF;
      ba = 2'h0;
      addr = 12'h000;
      #1;
      forever #40 ck = ~ck;
   end
   always @(ck) begin
      tick = tick + 1;
      half = (ck && cmd == CMD_READ) ? 0 : half + 1;
      if (dqOe && dqsOe) begin
         if (q.size() == 0) begin
            first = half;
            ft = tick;
         end
         q.push_back(dq);
         last = tick;
      end
   end
   task automatic start;
      repeat (4) @(negedge ck);
      cmd = 4'h7;
      cke = 1'b1;
   endtask
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      @(negedge ck);
      cmd = c;
      ba = b;
      addr = a;
      @(posedge ck);
      @(negedge ck);
      // Released lines flip so a stale value is never trusted
      cmd = 4'hF;
      ba = ~b;
      addr = ~a;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench for the DDR device core: init, mode writes, bank state, reads.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ddri_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ck, cke, dqOe, dqsOut, dqsOe, dllOn, halfDrive, dllLocking;
   ddri_cmd_s cmd;
   logic [1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dqOut;
   logic pEn = 1'b0;
   logic [MEM_AW-1:0] pAddr = 7'h00;
   logic [3:0] bankOpen;
   logic [11:0] modeReg;
   logic [12:0] extReg;
   logic [2:0] cls[3] = '{CL2, CL25, CL3};
   int fails = 0;
   int comparisons = 0;
   always #2.5 clk = ~clk;
   ddri_ctl_model u (.ck(ck), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr), .dq(dqOut), .dqOe(dqOe),
      .dqsOe(dqsOe));
   ddri_core DUT (.clk(clk), .rst(rst), .ck(ck), .cke(cke), .csN(cmd.csN), .rasN(cmd.rasN),
      .casN(cmd.casN), .weN(cmd.weN), .ba(ba), .addr(addr), .dqIn(dqOe ? dqOut : ~dqOut),
      .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsOe ? dqsOut : ~dqsOut), .dqsOut(dqsOut), .dqsOe(dqsOe),
      .preloadEn(pEn), .preloadAddr(pAddr), .preloadData(8'(pAddr) ^ 8'hA5), .bankOpen(bankOpen),
      .modeReg(modeReg), .extReg(extReg), .dllOn(dllOn), .halfDrive(halfDrive), .dllLocking(dllLocking));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [7:0] word(input logic [1:0] b, input logic [4:0] c, input int i, input int n,
      input logic bt);
      logic [4:0] off;
      off = bt ? (c ^ 5'(i)) : ((c & ~5'(n - 1)) | ((c + 5'(i)) & 5'(n - 1)));
      return 8'({b, off}) ^ 8'hA5;
   endfunction
   task automatic rd(input logic [2:0] blc, input logic bt, input logic [2:0] cl, input logic [1:0] b,
      input logic [4:0] c, input logic ap);
      int n;
      int lat;
      n = 1 << blc;
      lat = (cl == CL2) ? 5 : (cl == CL25) ? 6 : 7;
      // Mode write with all banks idle
      u.issue(CMD_MODE, 2'h0, {5'h00, cl, bt, blc});
      u.issue(CMD_ACT, b, 12'h000);
      u.q.delete();
      u.issue(CMD_READ, b, {1'b0, ap, 5'h00, c});
      repeat (14) @(posedge ck);
      check(u.q.size(), n);
      check(u.first, lat);
      for (int i = 0; i < n; i++) check(u.q[i], word(b, c, i, n, bt));
      check(bankOpen, ap ? 4'h0 : 4'h1 << b);
      check({dqsOe, dqsOut}, 2'h0);
      u.issue(CMD_PRE, 2'h0, 12'h400);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      check(modeReg, MODE_RST);
      check(extReg, EXT_RST);
      for (int i = 0; i < 128; i++) begin
         @(posedge clk);
         #1;
         pEn = 1'b1;
         pAddr = 7'(i);
      end
      @(posedge clk);
      #1;
      pEn = 1'b0;
      u.start();
      // Init order: precharge, extended, mode with loop reset
      u.issue(CMD_PRE, 2'h0, 12'h400);
      u.issue(CMD_MODE, 2'h3, 12'h002);
      check(halfDrive, 1'b1);
      check(extReg, 13'h1002);
      u.issue(CMD_MODE, 2'h1, 12'h000);
      check({dllOn, halfDrive}, 2'h2);
      check(extReg, 13'h0000);
      u.issue(CMD_MODE, 2'h0, 12'h132);
      check(modeReg, 12'h132);
      check(dllLocking, 1'b1);
      repeat (190) @(posedge ck);
      check(dllLocking, 1'b1);
      repeat (12) @(posedge ck);
      check(dllLocking, 1'b0);
      u.issue(4'h8, 2'h0, 12'h031);
      check(modeReg, 12'h132);
      for (int b = 0; b < 4; b++) u.issue(CMD_ACT, 2'(b), 12'h000);
      check(bankOpen, 4'hF);
      u.issue(CMD_PRE, 2'h0, 12'h400);
      check(bankOpen, 4'h0);
      u.q.delete();
      u.issue(CMD_READ, 2'h1, 12'h000);
      repeat (10) @(posedge ck);
      check(u.q.size(), 0);
      for (int l = 1; l < 4; l++) begin
         for (int t = 0; t < 2; t++) rd(3'(l), t[0], cls[(l + t) % 3], 2'(l), 5'h0D, t[0]);
      end
      u.issue(CMD_MODE, 2'h0, {5'h00, CL3, 1'b0, BL4});
      u.issue(CMD_ACT, 2'h2, 12'h000);
      u.q.delete();
      u.issue(CMD_READ, 2'h2, 12'h001);
      u.issue(CMD_READ, 2'h2, 12'h006);
      repeat (14) @(posedge ck);
      check(u.q.size(), 8);
      check(u.last - u.ft, 7);
      check(u.q[4], word(2'h2, 5'h06, 0, 4, 1'b0));
      give_verdict();
   end
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
